// ---- src/lsgr_pkg.sv ----
package lsgr_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [7:0] LSGR_CRC_COUNT_LOW_ADDR = 8'h0a;
   localparam logic [7:0] LSGR_CRC_COUNT_HIGH_ADDR = 8'h0b;
   localparam logic [7:0] LSGR_LINK_GENERAL_STATUS_ADDR = 8'h0c;
   localparam logic [7:0] LSGR_PIN_ZERO_CONFIG_ADDR = 8'h0d;

   // ****************************************************
   // Field positions and reset values
   // ****************************************************
   localparam int LSGR_STAT_LINK_LOST_BIT = 4;
   localparam int LSGR_STAT_SELF_TEST_CRC_BIT = 3;
   localparam int LSGR_STAT_CLOCK_DETECT_BIT = 2;
   localparam int LSGR_STAT_REMOTE_CRC_BIT = 1;
   localparam int LSGR_STAT_LINK_DETECT_BIT = 0;
   localparam int LSGR_CFG_VALUE_BIT = 3;
   localparam int LSGR_CFG_MODE_MSB = 2;
   localparam int LSGR_CFG_REV_LSB = 4;
   localparam int LSGR_ERROR_RESET_BIT = 5;
   localparam logic [15:0] LSGR_CRC_COUNT_RESET = 16'h0000;
   localparam logic [15:0] LSGR_CRC_COUNT_MAX = 16'hffff;
   localparam logic [3:0] LSGR_PIN_CFG_RESET = 4'h0;
   localparam logic [7:0] LSGR_READ_IDLE = 8'h00;
   // Arbitrary revision value
   localparam logic [3:0] LSGR_REVISION_DEFAULT = 4'h1;
   localparam int LSGR_PORTS = 2;

   // ****************************************************
   // Pin usage decoded from the 3-bit mode field
   // ****************************************************
   typedef enum logic [2:0]
   {
      LSGR_PIN_FUNCTIONAL = 3'b000,
      LSGR_PIN_HIGH_Z = 3'b001,
      LSGR_PIN_LOCAL_OUT = 3'b010,
      LSGR_PIN_GP_INPUT = 3'b011,
      LSGR_PIN_REMOTE_HOLD = 3'b100,
      LSGR_PIN_REMOTE_DEFAULT = 3'b101
   } lsgr_pin_use_type;

   // ****************************************************
   // Per-port state
   // ****************************************************
   typedef struct packed
   {
      logic [15:0] crc_count;
      logic link_lost;
      logic self_test_crc;
      logic remote_crc;
      logic link_prev;
      logic remote_held;
      logic [3:0] pin_cfg;
      logic pin_out;
      logic pin_oe_n;
      logic pin_input_value;
   } lsgr_port_type;

   typedef struct packed
   {
      lsgr_port_type [LSGR_PORTS-1:0] port;
      logic [7:0] rd_data;
      logic rd_valid;
   } lsgr_state_type;

endpackage : lsgr_pkg

// ---- src/lsgr_link_status_gpio_regs.sv ----
//
// Function
// - Sixteen-bit CRC error count, two read bytes
// - Error-reset bit clears both count bytes
// - Port select returns second port's values
// - Sticky link-lost bit until error reset
// - Self-test CRC flag, cleared loss/restart/reset
// - Status bit 2 shows input clock present
// - Normal CRC flag, cleared loss or reset
// - Status bit 0 shows cable link detected
// - Local output drives output-value bit
// - Mode x00 functional input, x10 high-Z
// - Mode 001 local output, 011 input
// - Mode 101 remote value, hold on loss
// - Mode 111 remote value, local on loss
// - Port select applies config to second pin
`timescale 1ns/10ps
module lsgr_link_status_gpio_regs
   import lsgr_pkg::*;
#(
   parameter logic [3:0] REVISION_ID = LSGR_REVISION_DEFAULT
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rd_data,
   output logic reg_rd_valid,
   input wire logic second_port_select,
   input wire logic error_reset,
   input wire logic input_clock_detect,
   input wire logic [1:0] link_detect,
   input wire logic [1:0] back_channel_crc_error,
   input wire logic [1:0] link_self_test_active,
   input wire logic [1:0] link_self_test_restart,
   input wire logic [1:0] remote_pin_value,
   input wire logic general_io_pin_zero_in,
   output logic general_io_pin_zero_out,
   output logic general_io_pin_zero_oe_n,
   input wire logic second_link_io_pin_zero_in,
   output logic second_link_io_pin_zero_out,
   output logic second_link_io_pin_zero_oe_n,
   output logic [1:0] pin_zero_input_value,
   output logic [1:0] pin_zero_functional_in
);

   // ****************************************************
   // Mode decoding
   // ****************************************************
   function automatic lsgr_pin_use_type lsgr_pin_use(input logic [2:0] mode);
      lsgr_pin_use_type use_kind;
      use_kind = LSGR_PIN_HIGH_Z;
      if (mode[1:0] == 2'b00)
         use_kind = LSGR_PIN_FUNCTIONAL;
      else if (mode[1:0] == 2'b10)
         use_kind = LSGR_PIN_HIGH_Z;
      else if (mode == 3'b001)
         use_kind = LSGR_PIN_LOCAL_OUT;
      else if (mode == 3'b011)
         use_kind = LSGR_PIN_GP_INPUT;
      else if (mode == 3'b101)
         use_kind = LSGR_PIN_REMOTE_HOLD;
      else
         use_kind = LSGR_PIN_REMOTE_DEFAULT;
      return use_kind;
   endfunction : lsgr_pin_use

   lsgr_state_type state;
   lsgr_state_type next_state;
   logic [1:0] pin_in;
   logic sel;

   assign pin_in = {second_link_io_pin_zero_in, general_io_pin_zero_in};
   assign sel = second_port_select;

   // ****************************************************
   // Next-state logic
   // ****************************************************
   always_comb
   begin
      lsgr_pin_use_type use_kind;
      logic link_loss;
      logic [15:0] cnt;
      use_kind = LSGR_PIN_HIGH_Z;
      link_loss = 1'b0;
      cnt = LSGR_CRC_COUNT_RESET;
      next_state = state;
      next_state.rd_valid = 1'b0;

      for (int p = 0; p < LSGR_PORTS; p++)
      begin
         link_loss = state.port[p].link_prev && !link_detect[p];
         next_state.port[p].link_prev = link_detect[p];

         // Clear first, then let a same-cycle error count on top of it
         cnt = error_reset ? LSGR_CRC_COUNT_RESET : state.port[p].crc_count;
         if (back_channel_crc_error[p] && cnt != LSGR_CRC_COUNT_MAX)
            cnt = cnt + 16'h0001;
         next_state.port[p].crc_count = cnt;

         if (link_loss)
            next_state.port[p].link_lost = 1'b1;
         else if (error_reset)
            next_state.port[p].link_lost = 1'b0;

         if (back_channel_crc_error[p] && link_self_test_active[p])
            next_state.port[p].self_test_crc = 1'b1;
         else if (link_loss || link_self_test_restart[p] || error_reset)
            next_state.port[p].self_test_crc = 1'b0;

         if (back_channel_crc_error[p] && !link_self_test_active[p])
            next_state.port[p].remote_crc = 1'b1;
         else if (link_loss || error_reset)
            next_state.port[p].remote_crc = 1'b0;

         // Config writes land only on the port picked by the select bit
         if (reg_wr_en && reg_addr == LSGR_PIN_ZERO_CONFIG_ADDR && (p == 1) == sel)
            next_state.port[p].pin_cfg = reg_wr_data[LSGR_CFG_VALUE_BIT:0];

         // Pin drive; the remote value is latched only while the link is up
         use_kind = lsgr_pin_use(next_state.port[p].pin_cfg[LSGR_CFG_MODE_MSB:0]);
         if (link_detect[p])
            next_state.port[p].remote_held = remote_pin_value[p];
         next_state.port[p].pin_oe_n = 1'b1;
         next_state.port[p].pin_out = 1'b0;
         case (use_kind)
            LSGR_PIN_LOCAL_OUT:
            begin
               next_state.port[p].pin_oe_n = 1'b0;
               next_state.port[p].pin_out = next_state.port[p].pin_cfg[LSGR_CFG_VALUE_BIT];
            end
            LSGR_PIN_REMOTE_HOLD:
            begin
               next_state.port[p].pin_oe_n = 1'b0;
               next_state.port[p].pin_out = next_state.port[p].remote_held;
            end
            LSGR_PIN_REMOTE_DEFAULT:
            begin
               next_state.port[p].pin_oe_n = 1'b0;
               if (link_detect[p])
                  next_state.port[p].pin_out = remote_pin_value[p];
               else
                  next_state.port[p].pin_out = next_state.port[p].pin_cfg[LSGR_CFG_VALUE_BIT];
            end
            LSGR_PIN_GP_INPUT:
               next_state.port[p].pin_input_value = pin_in[p];
            LSGR_PIN_FUNCTIONAL, LSGR_PIN_HIGH_Z:
               next_state.port[p].pin_oe_n = 1'b1;
            default:
               next_state.port[p].pin_oe_n = 1'b1;
         endcase
      end

      // ****************************************************
      // Register read, one cycle after the strobe
      // ****************************************************
      if (reg_rd_en)
      begin
         next_state.rd_valid = 1'b1;
         case (reg_addr)
            LSGR_CRC_COUNT_LOW_ADDR:
               next_state.rd_data = state.port[sel].crc_count[7:0];
            LSGR_CRC_COUNT_HIGH_ADDR:
               next_state.rd_data = state.port[sel].crc_count[15:8];
            LSGR_LINK_GENERAL_STATUS_ADDR:
            begin
               next_state.rd_data = LSGR_READ_IDLE;
               next_state.rd_data[LSGR_STAT_LINK_LOST_BIT] = state.port[sel].link_lost;
               next_state.rd_data[LSGR_STAT_SELF_TEST_CRC_BIT] = state.port[sel].self_test_crc;
               next_state.rd_data[LSGR_STAT_CLOCK_DETECT_BIT] = input_clock_detect;
               next_state.rd_data[LSGR_STAT_REMOTE_CRC_BIT] = state.port[sel].remote_crc;
               next_state.rd_data[LSGR_STAT_LINK_DETECT_BIT] = link_detect[sel];
            end
            LSGR_PIN_ZERO_CONFIG_ADDR:
               next_state.rd_data = {REVISION_ID, state.port[sel].pin_cfg};
            default:
               next_state.rd_data = LSGR_READ_IDLE;
         endcase
      end

      if (sys_rst)
      begin
         next_state = '0;
         for (int p = 0; p < LSGR_PORTS; p++)
         begin
            next_state.port[p].crc_count = LSGR_CRC_COUNT_RESET;
            next_state.port[p].pin_cfg = LSGR_PIN_CFG_RESET;
            next_state.port[p].pin_oe_n = 1'b1;
         end
      end
   end

   // ****************************************************
   // State register
   // ****************************************************
   always_ff @(posedge clk)
   begin
      state <= next_state;
   end

   assign reg_rd_data = state.rd_data;
   assign reg_rd_valid = state.rd_valid;
   assign general_io_pin_zero_out = state.port[0].pin_out;
   assign general_io_pin_zero_oe_n = state.port[0].pin_oe_n;
   assign second_link_io_pin_zero_out = state.port[1].pin_out;
   assign second_link_io_pin_zero_oe_n = state.port[1].pin_oe_n;
   assign pin_zero_input_value = {state.port[1].pin_input_value, state.port[0].pin_input_value};
   // Functional input path is the raw pin, passed on only in functional mode
   assign pin_zero_functional_in = pin_in & {lsgr_pin_use(state.port[1].pin_cfg[2:0]) == LSGR_PIN_FUNCTIONAL,
                                             lsgr_pin_use(state.port[0].pin_cfg[2:0]) == LSGR_PIN_FUNCTIONAL};

endmodule : lsgr_link_status_gpio_regs

// ---- testbench/lsgr_monitor.sv ----
`timescale 1ns/10ps
module lsgr_monitor
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic reg_rd_valid,
   input wire logic second_port_select,
   input wire logic error_reset,
   input wire logic input_clock_detect,
   input wire logic general_io_pin_zero_out,
   input wire logic general_io_pin_zero_oe_n,
   input wire logic second_link_io_pin_zero_out,
   input wire logic second_link_io_pin_zero_oe_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wr_data,
   input wire logic [7:0] reg_rd_data,
   input wire logic [1:0] link_detect,
   input wire logic [1:0] back_channel_crc_error
);
   default clocking mon_clk @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence wr_cfg(sel, mode);
      reg_wr_en && reg_addr == 8'h0d && second_port_select == sel && reg_wr_data[2:0] == mode;
   endsequence
   sequence rd_stat;
      reg_rd_en && reg_addr == 8'h0c;
   endsequence
   a_read_answered: assert property (reg_rd_en ##1 !reg_rd_en |-> reg_rd_valid ##1 !reg_rd_valid)
      else $error("read valid wrong");
   a_clock_bit_live: assert property (rd_stat |=> reg_rd_data[2] == $past(input_clock_detect))
      else $error("clock bit wrong");
   a_link_bit_port: assert property (rd_stat |=> reg_rd_data[0] == $past(link_detect[second_port_select]))
      else $error("link bit wrong");
   a_count_cleared: assert property (error_reset && !back_channel_crc_error ##1 reg_rd_en && reg_addr[7:1] == 7'h05
      |=> reg_rd_data == 8'h00) else $error("count not cleared");
   a_loss_flags: assert property ($fell(link_detect[0]) && !error_reset && !back_channel_crc_error[0]
      ##1 rd_stat ##0 !second_port_select |=> reg_rd_data[4:3] == 2'b10 && !reg_rd_data[1])
      else $error("loss flags wrong");
   a_local_drive: assert property (wr_cfg(1'b0, 3'b001) |=>
      !general_io_pin_zero_oe_n && general_io_pin_zero_out == $past(reg_wr_data[3])) else $error("pin not driven");
   a_pin_released: assert property (wr_cfg(1'b0, 3'b010) |=> general_io_pin_zero_oe_n [*2])
      else $error("pin not released");
   a_second_pin: assert property (wr_cfg(1'b1, 3'b001) |=>
      !second_link_io_pin_zero_oe_n && second_link_io_pin_zero_out == $past(reg_wr_data[3]))
      else $error("second pin wrong");
endmodule : lsgr_monitor
bind lsgr_link_status_gpio_regs lsgr_monitor i_lsgr_monitor (.*);

// ---- testbench/lsgr_far.sv ----
`timescale 1ns/10ps
module lsgr_far
(
   input wire logic clk,
   output logic [1:0] link_detect,
   output logic [1:0] back_channel_crc_error,
   output logic [1:0] link_self_test_active,
   output logic [1:0] link_self_test_restart,
   output logic [1:0] remote_pin_value
);
   logic [1:0] pin_value;
   // A dropped link carries no pin data, so show the inverse rather than a stale value
   assign remote_pin_value = pin_value ^ ~link_detect;
   initial
   begin
      {link_detect, back_channel_crc_error, link_self_test_active, link_self_test_restart, pin_value} = 10'h300;
   end
   task burst(input int p, input int n);
      back_channel_crc_error[p] = 1'b1;
      repeat (n) @(negedge clk);
      back_channel_crc_error[p] = 1'b0;
   endtask : burst
endmodule : lsgr_far

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
   import lsgr_pkg::*;
   logic clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, second_port_select, error_reset, input_clock_detect;
   logic general_io_pin_zero_out, general_io_pin_zero_oe_n, second_link_io_pin_zero_out, second_link_io_pin_zero_oe_n;
   logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
   logic [1:0] link_detect, back_channel_crc_error, link_self_test_active, link_self_test_restart, remote_pin_value;
   logic [1:0] pin_zero_input_value, pin_zero_functional_in;
   logic [11:0] pin_tab [8] = '{12'h047, 12'h026, 12'h095, 12'h0b6, 12'h05d, 12'h059, 12'h0f4, 12'h0f9};
   int bad_count = 0;
   int tests_run = 0;
   // Pull-ups on the pins keep a released line at a defined high level
   wire logic general_io_pin_zero_in = general_io_pin_zero_oe_n | general_io_pin_zero_out;
   wire logic second_link_io_pin_zero_in = second_link_io_pin_zero_oe_n | second_link_io_pin_zero_out;
   lsgr_link_status_gpio_regs i_lsgr_link_status_gpio_regs (.*);
   lsgr_far i_lsgr_far (.*);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      bad_count += int'(seen !== exp);
      if (seen !== exp)
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
   endtask : check
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wr_data = d;
      {reg_wr_en, reg_rd_en} = {w, !w};
      @(negedge clk);
      {reg_wr_en, reg_rd_en} = 2'b00;
      if (!w)
         check(reg_rd_valid === 1'b1 ? reg_rd_data : 8'hxx, d);
      @(negedge clk);
   endtask : acc
   task print_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      #2500000;
      bad_count++;
      print_verdict();
   end
   initial
   begin
      {sys_rst, reg_wr_en, reg_rd_en, second_port_select, error_reset, input_clock_detect} = 6'h21;
      {reg_addr, reg_wr_data} = 16'h0000;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      acc(1'b1, 8'h0a, 8'hff);
      acc(1'b0, 8'h0a, 8'h00);
      acc(1'b0, 8'h0c, 8'h05);
      acc(1'b0, 8'h0d, {LSGR_REVISION_DEFAULT, 4'h0});
      acc(1'b0, 8'h0e, 8'h00);
      $display("reset test done");
      i_lsgr_far.burst(0, 3);
      acc(1'b0, 8'h0c, 8'h07);
      second_port_select = 1'b1;
      // Two pulses past the top of the count
      i_lsgr_far.burst(1, 65537);
      acc(1'b0, 8'h0a, 8'hff);
      acc(1'b0, 8'h0b, 8'hff);
      second_port_select = 1'b0;
      acc(1'b0, 8'h0a, 8'h03);
      error_reset = 1'b1;
      @(negedge clk);
      error_reset = 1'b0;
      acc(1'b0, 8'h0a, 8'h00);
      $display("count test done");
      i_lsgr_far.link_self_test_active[0] = 1'b1;
      i_lsgr_far.burst(0, 1);
      acc(1'b0, 8'h0c, 8'h0d);
      i_lsgr_far.link_self_test_restart[0] = 1'b1;
      @(negedge clk);
      i_lsgr_far.link_self_test_restart[0] = 1'b0;
      acc(1'b0, 8'h0c, 8'h05);
      i_lsgr_far.burst(0, 1);
      i_lsgr_far.link_self_test_active[0] = 1'b0;
      i_lsgr_far.burst(0, 1);
      i_lsgr_far.link_detect[0] = 1'b0;
      @(negedge clk);
      acc(1'b0, 8'h0c, 8'h14);
      i_lsgr_far.link_detect[0] = 1'b1;
      acc(1'b0, 8'h0c, 8'h15);
      $display("status test done");
      foreach (pin_tab[i])
      begin
         {i_lsgr_far.pin_value[0], i_lsgr_far.link_detect[0]} = pin_tab[i][3:2];
         acc(1'b1, 8'h0d, pin_tab[i][11:4]);
         check({6'h00, general_io_pin_zero_oe_n, general_io_pin_zero_oe_n ? pin_zero_functional_in[0] :
            general_io_pin_zero_out}, {6'h00, pin_tab[i][1:0]});
      end
      check({7'h00, pin_zero_input_value[0]}, 8'h01);
      second_port_select = 1'b1;
      acc(1'b1, 8'h0d, 8'h09);
      check({6'h00, second_link_io_pin_zero_oe_n, second_link_io_pin_zero_out}, 8'h01);
      acc(1'b0, 8'h0d, {LSGR_REVISION_DEFAULT, 4'h9});
      $display("pin test done");
      print_verdict();
   end
endmodule : testbench
